/* core/clk_ctrl_pkg.sv */
// constants for the clock source and pll control block
package clk_ctrl_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // register byte offsets
   localparam logic [7:0] OSC_CTRL_OFF = 8'h00;
   localparam logic [7:0] STATUS_OFF = 8'h04;
   localparam logic [7:0] IRQ_STATUS_OFF = 8'h08;
   localparam logic [7:0] IRQ_MASK_OFF = 8'h0c;
   localparam logic [7:0] PBA_MASK_OFF = 8'h10;
   localparam logic [7:0] MAIN_SEL_OFF = 8'h14;
   localparam logic [7:0] PERIPH_PWR_OFF = 8'h18;
   localparam logic [7:0] RANGE_TOP_OFF = 8'h1c;
   // unlock key
   localparam logic [31:0] UNLOCK_KEY = 32'h5a5a5a5a;
   // osc_ctrl fields
   localparam int LP_RC_EN_BIT = 0;
   localparam int PLL_EN_BIT = 1;
   localparam int CFD_EN_BIT = 2;
   localparam int LOCK_CNT_LSB = 8;
   localparam int LOCK_CNT_W = 4;
   // status fields
   localparam int ST_LP_RC_BIT = 0;
   localparam int ST_LOCK_BIT = 1;
   localparam int ST_UNLOCK_BIT = 2;
   localparam int ST_ON_SYSRC_BIT = 3;
   // interrupt events
   localparam int IRQ_W = 3;
   localparam int EV_CFD = 0;
   localparam int EV_LOCK = 1;
   localparam int EV_LP_RC = 2;
   // peripheral power control fields
   localparam int ROUTE_BIT = 0;
   // reset values
   localparam logic [31:0] PBA_MASK_RST = 32'h0e00_0000;
   localparam logic [31:0] PERIPH_PWR_RST = 32'h0000_0001;
   // main clock sources
   typedef enum logic [1:0] {
      SRC_SYSRC = 2'b00,
      SRC_OSC = 2'b01,
      SRC_PLL = 2'b10,
      SRC_DFLL = 2'b11
   } main_src_t;
   localparam int SYNC_STAGES = 2;
endpackage : clk_ctrl_pkg

/* core/bit_sync.sv */
// two-flop synchroniser bank for oscillator status levels
`timescale 1ns/1ns
module bit_sync
   import clk_ctrl_pkg::*;
#(
   parameter int WIDTH = 1
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   // one pair of flops per bit; stage one feeds only stage two
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         logic meta_reg;
         logic stable_reg;
         always_ff @(posedge clk or posedge rst)
         begin
            if (rst)
            begin
               meta_reg <= 1'b0;
               stable_reg <= 1'b0;
            end
            else if (ce)
            begin
               meta_reg <= async_in[i];
               stable_reg <= meta_reg;
            end
         end
         assign sync_out[i] = stable_reg;
      end
   endgenerate
endmodule : bit_sync

/* core/clock_source_and_pll_control.sv */
// clock source, pll, failure detector and bus clock mask control
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ns
// Overview of operation
// - rc enable readback shows real oscillator state
// - key write anywhere in range unlocks
// - failure flag forces main clock to rc
// - sleepwalk masks all other bus clocks
// - three spare bus clocks enabled at reset
module clock_source_and_pll_control
   import clk_ctrl_pkg::*;
#(
   parameter int NUM_PB = 32
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [DATA_W-1:0] rdata,
   input wire logic lp_rc_ready_async,
   input wire logic pll_lock_async,
   input wire logic clk_fail_async,
   input wire logic sleep_idle_frozen,
   input wire logic [NUM_PB-1:0] sleepwalk_req,
   output logic low_power_rc_osc_en,
   output logic pll_enable_signal,
   output logic clock_failure_detect_en,
   output logic rc_output_pin_en,
   output logic [1:0] main_src,
   output logic [NUM_PB-1:0] pb_clk_en,
   output logic irq
);
   logic [DATA_W-1:0] osc_ctrl_reg;
   logic [IRQ_W-1:0] irq_status_reg;
   logic [IRQ_W-1:0] irq_mask_reg;
   logic [NUM_PB-1:0] pba_mask_reg;
   logic [1:0] main_src_reg;
   logic [DATA_W-1:0] periph_pwr_reg;
   logic unlock_reg;
   logic cfd_en_prev_reg;
   logic lock_prev_reg;
   logic lp_rc_prev_reg;
   logic [LOCK_CNT_W-1:0] lock_cnt_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic [2:0] synced;
   logic lp_rc_ready;
   logic pll_lock_raw;
   logic clk_fail;
   logic lock_flag;
   logic cfd_set;
   logic [IRQ_W-1:0] ev;
   logic in_range;
   logic key_wr;
   logic pll_en_rise;
   logic [LOCK_CNT_W-1:0] lock_cnt_cfg;

   // oscillator status levels into the bus domain
   bit_sync #(.WIDTH(3)) u_sync (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .async_in({clk_fail_async, pll_lock_async, lp_rc_ready_async}),
      .sync_out(synced)
   );
   assign lp_rc_ready = synced[0];
   assign pll_lock_raw = synced[1];
   assign clk_fail = synced[2];

   // address decode and key detect
   assign in_range = addr < RANGE_TOP_OFF;
   assign key_wr = wr_en && in_range && (wdata == UNLOCK_KEY);
   assign lock_cnt_cfg = osc_ctrl_reg[LOCK_CNT_LSB +: LOCK_CNT_W];
   assign pll_en_rise = wr_en && !key_wr && (addr == OSC_CTRL_OFF) && wdata[PLL_EN_BIT]
      && !osc_ctrl_reg[PLL_EN_BIT];

   // failure seen while enabled or in the cycle it is switched off
   assign cfd_set = clk_fail && (osc_ctrl_reg[CFD_EN_BIT] || cfd_en_prev_reg);
   assign lock_flag = pll_lock_raw && (lock_cnt_reg == '0) && osc_ctrl_reg[PLL_EN_BIT];
   assign ev[EV_CFD] = cfd_set;
   assign ev[EV_LOCK] = lock_flag && !lock_prev_reg;
   assign ev[EV_LP_RC] = lp_rc_ready != lp_rc_prev_reg;

   // oscillator control register
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         osc_ctrl_reg <= '0;
      else if (ce && wr_en && !key_wr && addr == OSC_CTRL_OFF)
         osc_ctrl_reg <= wdata & 32'h0000_0f07;
   end

   // lock mask counter loaded on pll enable
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         lock_cnt_reg <= '0;
      else if (ce)
      begin
         if (pll_en_rise)
            lock_cnt_reg <= wdata[LOCK_CNT_LSB +: LOCK_CNT_W];
         else if (lock_cnt_reg != '0)
            lock_cnt_reg <= lock_cnt_reg - 1'b1;
      end
   end

   // edge history for events
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cfd_en_prev_reg <= 1'b0;
         lock_prev_reg <= 1'b0;
         lp_rc_prev_reg <= 1'b0;
      end
      else if (ce)
      begin
         cfd_en_prev_reg <= osc_ctrl_reg[CFD_EN_BIT];
         lock_prev_reg <= lock_flag;
         lp_rc_prev_reg <= lp_rc_ready;
      end
   end

   // sticky events, write one to clear, set wins
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         irq_status_reg <= '0;
      else if (ce)
      begin
         if (wr_en && !key_wr && addr == IRQ_STATUS_OFF)
            irq_status_reg <= (irq_status_reg & ~wdata[IRQ_W-1:0]) | ev;
         else
            irq_status_reg <= irq_status_reg | ev;
      end
   end

   // interrupt mask
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         irq_mask_reg <= '0;
      else if (ce && wr_en && !key_wr && addr == IRQ_MASK_OFF)
         irq_mask_reg <= wdata[IRQ_W-1:0];
   end

   // bus clock mask, spare clocks on at reset
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         pba_mask_reg <= PBA_MASK_RST[NUM_PB-1:0];
      else if (ce && wr_en && !key_wr && addr == PBA_MASK_OFF)
         pba_mask_reg <= wdata[NUM_PB-1:0];
   end

   // peripheral power control, holds rc output route
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         periph_pwr_reg <= PERIPH_PWR_RST;
      else if (ce && wr_en && !key_wr && addr == PERIPH_PWR_OFF)
         periph_pwr_reg <= wdata & 32'h0000_0001;
   end

   // unlock armed by key, consumed by next write
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         unlock_reg <= 1'b0;
      else if (ce && wr_en)
         unlock_reg <= key_wr;
   end

   // main clock select, locked unless armed, failure forces rc
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         main_src_reg <= SRC_SYSRC;
      else if (ce)
      begin
         if (cfd_set)
            main_src_reg <= SRC_SYSRC;
         else if (wr_en && !key_wr && unlock_reg && addr == MAIN_SEL_OFF)
            main_src_reg <= wdata[1:0];
      end
   end

   // read data, one cycle after strobe
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rdata_reg <= '0;
      else if (ce)
      begin
         rdata_reg <= '0;
         if (rd_en)
         begin
            if (addr == OSC_CTRL_OFF)
               rdata_reg <= {osc_ctrl_reg[DATA_W-1:1], lp_rc_ready};
            else if (addr == STATUS_OFF)
               rdata_reg <= {28'h0000000, main_src_reg == SRC_SYSRC, unlock_reg, lock_flag, lp_rc_ready};
            else if (addr == IRQ_STATUS_OFF)
               rdata_reg <= {29'h0000000, irq_status_reg};
            else if (addr == IRQ_MASK_OFF)
               rdata_reg <= {29'h0000000, irq_mask_reg};
            else if (addr == PBA_MASK_OFF)
               rdata_reg <= DATA_W'(pba_mask_reg);
            else if (addr == MAIN_SEL_OFF)
               rdata_reg <= {30'h00000000, main_src_reg};
            else if (addr == PERIPH_PWR_OFF)
               rdata_reg <= periph_pwr_reg;
         end
      end
   end

   // outputs
   assign rdata = rdata_reg;
   assign low_power_rc_osc_en = osc_ctrl_reg[LP_RC_EN_BIT];
   assign pll_enable_signal = osc_ctrl_reg[PLL_EN_BIT];
   assign clock_failure_detect_en = osc_ctrl_reg[CFD_EN_BIT];
   assign rc_output_pin_en = periph_pwr_reg[ROUTE_BIT] && lp_rc_ready;
   assign main_src = main_src_reg;
   assign irq = |(irq_status_reg & irq_mask_reg);

   // sleepwalk keeps only the requesting module's clock
   assign pb_clk_en = (sleep_idle_frozen && |sleepwalk_req) ? (pba_mask_reg & sleepwalk_req)
      : pba_mask_reg;

   // checks
   a_key_unlocks: assert property (@(posedge clk) disable iff (rst)
      ce && wr_en && in_range && wdata == UNLOCK_KEY |=> unlock_reg)
      else $error("key write did not unlock");
   a_cfd_fallback: assert property (@(posedge clk) disable iff (rst)
      ce && cfd_set |=> main_src == SRC_SYSRC && irq_status_reg[EV_CFD])
      else $error("failure did not force system rc");
   a_sleepwalk_mask: assert property (@(posedge clk) disable iff (rst)
      sleep_idle_frozen && |sleepwalk_req |-> (pb_clk_en & ~sleepwalk_req) == '0)
      else $error("other bus clocks left running in sleepwalk");
   a_spare_reset: assert property (@(posedge clk)
      $fell(rst) |-> pba_mask_reg[27:25] == 3'b111)
      else $error("spare bus clocks not on after reset");
   a_readback_real: assert property (@(posedge clk) disable iff (rst)
      ce && rd_en && addr == OSC_CTRL_OFF |=> rdata[0] == $past(lp_rc_ready))
      else $error("rc enable readback not real state");
   a_sync_delay: assert property (@(posedge clk) disable iff (rst)
      ce [*3] |-> lp_rc_ready == $past(lp_rc_ready_async, 2))
      else $error("status not two stages behind");
   a_lock_masked: assert property (@(posedge clk) disable iff (rst)
      lock_cnt_reg != '0 |-> !lock_flag)
      else $error("lock flag shown during mask count");
   a_irq_level: assert property (@(posedge clk) disable iff (rst)
      ce && ev[EV_CFD] && irq_mask_reg[EV_CFD] |=> irq)
      else $error("unmasked event gave no interrupt");
   a_locked_sel: assert property (@(posedge clk) disable iff (rst)
      ce && !unlock_reg && !cfd_set |=> main_src_reg == $past(main_src_reg))
      else $error("clock select changed while locked");
endmodule : clock_source_and_pll_control

/* tb/tb.sv */
// self-checking bench for the clock source and pll control block
`timescale 1ns/1ns
module tb
   import clk_ctrl_pkg::*;
;
   logic clk;
   logic rst;
   logic ce;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic wr_en;
   logic rd_en;
   logic [DATA_W-1:0] rdata;
   logic lp_rc_ready_async;
   logic pll_lock_async;
   logic clk_fail_async;
   logic sleep_idle_frozen;
   logic [31:0] sleepwalk_req;
   logic low_power_rc_osc_en;
   logic pll_enable_signal;
   logic clock_failure_detect_en;
   logic rc_output_pin_en;
   logic [1:0] main_src;
   logic [31:0] pb_clk_en;
   logic irq;
   logic [31:0] rd_val;
   int err_count;
   int cmp_count;

   clock_source_and_pll_control #(.NUM_PB(32)) i_clock_source_and_pll_control (
      .clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
      .rdata(rdata), .lp_rc_ready_async(lp_rc_ready_async), .pll_lock_async(pll_lock_async),
      .clk_fail_async(clk_fail_async), .sleep_idle_frozen(sleep_idle_frozen),
      .sleepwalk_req(sleepwalk_req), .low_power_rc_osc_en(low_power_rc_osc_en),
      .pll_enable_signal(pll_enable_signal), .clock_failure_detect_en(clock_failure_detect_en),
      .rc_output_pin_en(rc_output_pin_en), .main_src(main_src), .pb_clk_en(pb_clk_en), .irq(irq));

   // 100 mhz clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // verdict and end of run
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      #1;
   endtask : wr

   // read data stands in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      d = rdata;
   endtask : rd

   // poll the rc enable bit until it reads the wanted level
   task automatic poll_rc(input logic want);
      logic [31:0] v;
      int n;
      for (n = 0; n < 8; n++)
      begin
         rd(OSC_CTRL_OFF, v);
         if (v[0] === want)
            break;
      end
      chk({31'h0, v[0]}, {31'h0, want});
      if (n == 8)
         give_verdict();
   endtask : poll_rc

   task automatic reset_values();
      chk(pb_clk_en, 32'h0e00_0000);
      rd(PBA_MASK_OFF, rd_val);
      chk(rd_val, 32'h0e00_0000);
      wr(PBA_MASK_OFF, 32'h0);
      chk(pb_clk_en, 32'h0);
      rd(8'h40, rd_val);
      chk(rd_val, 32'h0);
   endtask : reset_values

   task automatic rc_readback();
      wr(OSC_CTRL_OFF, 32'h1);
      chk({31'h0, low_power_rc_osc_en}, 32'h1);
      rd(OSC_CTRL_OFF, rd_val);
      chk({31'h0, rd_val[0]}, 32'h0);
      @(posedge clk);
      lp_rc_ready_async <= 1'b1;
      poll_rc(1'b1);
      chk({31'h0, rc_output_pin_en}, 32'h1);
      wr(OSC_CTRL_OFF, 32'h0);
      @(posedge clk);
      lp_rc_ready_async <= 1'b0;
      poll_rc(1'b0);
   endtask : rc_readback

   task automatic unlock_key();
      wr(MAIN_SEL_OFF, 32'h1);
      repeat (2) @(posedge clk);
      chk({30'h0, main_src}, 32'h0);
      wr(IRQ_STATUS_OFF, UNLOCK_KEY);
      wr(MAIN_SEL_OFF, 32'h2);
      repeat (2) @(posedge clk);
      chk({30'h0, main_src}, 32'h2);
      wr(MAIN_SEL_OFF, 32'h1);
      repeat (2) @(posedge clk);
      chk({30'h0, main_src}, 32'h2);
   endtask : unlock_key

   task automatic clock_failure();
      wr(IRQ_MASK_OFF, 32'h0);
      wr(OSC_CTRL_OFF, 32'h4);
      @(posedge clk);
      clk_fail_async <= 1'b1;
      repeat (5) @(posedge clk);
      #1;
      chk({30'h0, main_src}, 32'h0);
      chk({31'h0, irq}, 32'h0);
      rd(IRQ_STATUS_OFF, rd_val);
      chk({31'h0, rd_val[EV_CFD]}, 32'h1);
      wr(IRQ_MASK_OFF, 32'h1);
      chk({31'h0, irq}, 32'h1);
      @(posedge clk);
      clk_fail_async <= 1'b0;
      repeat (4) @(posedge clk);
      wr(IRQ_STATUS_OFF, 32'h1);
      #1;
      chk({31'h0, irq}, 32'h0);
   endtask : clock_failure

   task automatic sleepwalk();
      wr(PBA_MASK_OFF, 32'hffff_ffff);
      @(posedge clk);
      sleep_idle_frozen <= 1'b1;
      sleepwalk_req <= 32'h0000_0008;
      @(posedge clk);
      #1;
      chk(pb_clk_en, 32'h0000_0008);
      @(posedge clk);
      sleep_idle_frozen <= 1'b0;
      @(posedge clk);
      #1;
      chk(pb_clk_en, 32'hffff_ffff);
   endtask : sleepwalk

   // detector off on system rc, then park the rc output
   task automatic rc_park();
      chk({31'h0, clock_failure_detect_en}, 32'h1);
      chk({30'h0, main_src}, 32'h0);
      wr(OSC_CTRL_OFF, 32'h0);
      chk({31'h0, clock_failure_detect_en}, 32'h0);
      chk({30'h0, main_src}, 32'h0);
      wr(PERIPH_PWR_OFF, 32'h0);
      wr(OSC_CTRL_OFF, 32'h1);
      @(posedge clk);
      lp_rc_ready_async <= 1'b1;
      poll_rc(1'b1);
      chk({31'h0, rc_output_pin_en}, 32'h0);
      wr(OSC_CTRL_OFF, 32'h0);
      @(posedge clk);
      lp_rc_ready_async <= 1'b0;
      poll_rc(1'b0);
   endtask : rc_park

   // pll on with zero mask count, wait before trusting lock, off before sleep
   task automatic pll_lock();
      wr(OSC_CTRL_OFF, 32'h2);
      chk({31'h0, pll_enable_signal}, 32'h1);
      @(posedge clk);
      pll_lock_async <= 1'b1;
      repeat (3000) @(posedge clk);
      rd(STATUS_OFF, rd_val);
      chk({31'h0, rd_val[ST_LOCK_BIT]}, 32'h1);
      rd(IRQ_STATUS_OFF, rd_val);
      chk({31'h0, rd_val[EV_LOCK]}, 32'h1);
      wr(OSC_CTRL_OFF, 32'h0);
      chk({31'h0, pll_enable_signal}, 32'h0);
      rd(STATUS_OFF, rd_val);
      chk({31'h0, rd_val[ST_LOCK_BIT]}, 32'h0);
      @(posedge clk);
      pll_lock_async <= 1'b0;
   endtask : pll_lock

   // hang guard
   initial
   begin
      #1000000;
      err_count++;
      give_verdict();
   end

   // main sequence
   initial
   begin
      err_count = 0;
      cmp_count = 0;
      rst = 1'b1;
      ce = 1'b1;
      addr = 8'h00;
      wdata = 32'h0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      lp_rc_ready_async = 1'b0;
      pll_lock_async = 1'b0;
      clk_fail_async = 1'b0;
      sleep_idle_frozen = 1'b0;
      sleepwalk_req = 32'h0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      reset_values();
      rc_readback();
      unlock_key();
      clock_failure();
      rc_park();
      pll_lock();
      sleepwalk();
      give_verdict();
   end
endmodule : tb
